/* verilog/wdt_pkg.sv */
package wdt_pkg;
   // Wishbone register byte offsets.
   localparam logic [3:0] WDT_CTRL_OFS    = 4'h0;
   localparam logic [3:0] WDT_RELOAD_OFS  = 4'h4;
   localparam logic [3:0] WDT_FEED_OFS    = 4'h8;
   localparam logic [3:0] WDT_STATUS_OFS  = 4'hC;
   localparam logic [3:0] WDT_IRQST_OFS   = 4'h0;
   localparam logic [3:0] WDT_IRQMSK_OFS  = 4'h4;
   // Control and interrupt field positions.
   localparam int WDT_CTRL_RUN_BIT   = 0;
   localparam int WDT_CTRL_MODE_BIT  = 1;
   localparam int WDT_CTRL_CLKSEL_BIT = 2;
   localparam int WDT_CTRL_TAP_LSB   = 4;
   localparam int WDT_IRQ_TIMEOUT_BIT = 0;
   localparam int WDT_IRQ_BADFEED_BIT = 1;
   // Reset values.
   localparam logic [7:0] WDT_CTRL_RST   = 8'h73;
   localparam logic [7:0] WDT_RELOAD_RST = 8'hFF;
   localparam logic [1:0] WDT_IRQMSK_RST = 2'h0;
   // Feed sequence bytes.
   localparam logic [7:0] WDT_FEED_FIRST  = 8'hA5;
   localparam logic [7:0] WDT_FEED_SECOND = 8'h5A;
   // Timing.
   localparam int WDT_PRESCALE_BITS = 12;
   localparam int WDT_COUNT_BITS    = 8;
   localparam int WDT_TAP_BASE      = 4;
   localparam int WDT_CLK_MHZ       = 250;
   localparam int WDT_RESET_PULSE_NS = 40;
   localparam int WDT_RESET_PULSE_CYC =
      (WDT_RESET_PULSE_NS * WDT_CLK_MHZ + 999) / 1000;
endpackage : wdt_pkg

/* verilog/wdt_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_sync
   import wdt_pkg::*;
(
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Levels.
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic meta_ff;

   // The first stage feeds only the second.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         meta_ff <= asyncIn;
         syncOut <= meta_ff;
      end
   end
endmodule : wdt_sync
`default_nettype wire

/* verilog/wdt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
   import wdt_pkg::*;
#(
   parameter int WIDTH = WDT_PRESCALE_BITS
) (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst,
   // Control.
   input  wire logic       advance,
   input  wire logic       clear,
   input  wire logic [2:0] tapSel,
   // Tap pulse.
   output logic            tapPulse
);
   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;
   logic [3:0]       tapIdx;

   // R11 eight tap ratios
   // Tap seven lands on the top bit, so no tap reads past the prescaler.
   assign tapIdx = 4'(WDT_TAP_BASE) + 4'(tapSel);
   assign nxt_count = count_ff + WIDTH'(1);

   // R2 twelve bit prescaler
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
      end else if (clear) begin
         count_ff <= '0;
      end else if (advance) begin
         count_ff <= nxt_count;
      end
   end

   // R3 tap rising carry
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tapPulse <= 1'b0;
      end else begin
         tapPulse <= advance && !clear && nxt_count[tapIdx]
                     && !count_ff[tapIdx];
      end
   end
endmodule : wdt_prescaler
`default_nettype wire

/* verilog/wdt_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Underflow in watchdog mode resets system.
// R2: Twelve-bit prescaler feeding eight-bit down counter.
// R3: Counter decrements on selected prescaler tap.
// R4: Prescaler clock: peripheral clock or oscillator.
// R5: Only power-on reset clears timer state.
// R6: Interval mode raises interrupt per timeout.
// R7: Software feeds with two ordered byte writes.
// R8: Peripheral clock source stops in power-down.
// R9: Mode bit one selects watchdog, zero interval.
// R10: Valid feed reloads counter, clears prescaler.
// R11: Three-bit field picks one of eight taps.
module wdt_interval_timer
   import wdt_pkg::*;
#(
   parameter int RESET_CYCLES = WDT_RESET_PULSE_CYC
) (
   // Clock and power-on reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Clock sources and power state.
   input  wire logic        peripheralClkTick,
   input  wire logic        watchdogOsc,
   input  wire logic        powerDown,
   // Outputs.
   output logic             systemResetReq,
   output logic             irq
);
   logic [7:0]  ctrl_ff;
   logic [7:0]  reload_ff;
   logic [7:0]  count_ff;
   logic        feedArmed_ff;
   logic [1:0]  irqStat_ff;
   logic [1:0]  irqMask_ff;
   logic        oscPrev_ff;
   logic [7:0]  rstCnt_ff;
   logic        oscSync;
   logic        oscEdge;
   logic        advance;
   logic        tapPulse;
   logic        feedOk;
   logic        underflow;
   logic        wbReq;
   logic        wrEn;
   logic        byte0;
   logic        hiBank;
   logic [3:0]  ofs;
   logic [1:0]  evSet;
   logic        running;
   logic        wdMode;
   logic        useOsc;
   logic [31:0] nxt_rdData;

   assign wbReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrEn   = wbReq && wb_we_i;
   assign byte0  = wb_sel_i[0];
   assign hiBank = wb_adr_i[4];
   assign ofs    = wb_adr_i[3:0];
   assign running = ctrl_ff[WDT_CTRL_RUN_BIT];
   assign wdMode  = ctrl_ff[WDT_CTRL_MODE_BIT];
   assign useOsc  = ctrl_ff[WDT_CTRL_CLKSEL_BIT];

   wdt_sync u_oscSync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn (watchdogOsc),
      .syncOut (oscSync)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oscPrev_ff <= 1'b0;
      end else begin
         oscPrev_ff <= oscSync;
      end
   end
   assign oscEdge = oscSync && !oscPrev_ff;

   // R4 source select
   // R8 stop in power-down
   assign advance = running
                    && (useOsc ? oscEdge
                               : (peripheralClkTick && !powerDown));

   wdt_prescaler #(
      .WIDTH (WDT_PRESCALE_BITS)
   ) u_prescaler (
      .clock    (clock),
      .rst      (rst),
      .advance  (advance),
      .clear    (feedOk || !running),
      .tapSel   (ctrl_ff[WDT_CTRL_TAP_LSB +: 3]),
      .tapPulse (tapPulse)
   );

   // R7 ordered feed bytes
   assign feedOk = wrEn && byte0 && !hiBank && ofs == WDT_FEED_OFS
                   && feedArmed_ff && wb_dat_i[7:0] == WDT_FEED_SECOND;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         feedArmed_ff <= 1'b0;
      end else if (wrEn) begin
         feedArmed_ff <= byte0 && !hiBank && ofs == WDT_FEED_OFS
                         && wb_dat_i[7:0] == WDT_FEED_FIRST;
      end
   end

   // Control registers; rst is the power-on reset only.
   // R5 power-on reset only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_ff   <= WDT_CTRL_RST;
         reload_ff <= WDT_RELOAD_RST;
      end else if (wrEn && byte0 && !hiBank) begin
         if (ofs == WDT_CTRL_OFS) begin
            ctrl_ff <= wb_dat_i[7:0];
         end
         if (ofs == WDT_RELOAD_OFS) begin
            reload_ff <= wb_dat_i[7:0];
         end
      end
   end

   assign underflow = running && tapPulse && count_ff == 8'h00;

   // R2 eight bit counter
   // R10 feed reloads
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_ff <= WDT_RELOAD_RST;
      end else if (feedOk || !running || underflow) begin
         count_ff <= reload_ff;
      end else if (tapPulse) begin
         // R3 decrement on tap
         count_ff <= count_ff - 8'h01;
      end
   end

   // R1 reset on underflow
   // R9 mode bit steers
   // A stretched pulse gives the reset tree time to act.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rstCnt_ff <= 8'h00;
      end else if (underflow && wdMode) begin
         rstCnt_ff <= 8'(RESET_CYCLES);
      end else if (rstCnt_ff != 8'h00) begin
         rstCnt_ff <= rstCnt_ff - 8'h01;
      end
   end
   assign systemResetReq = rstCnt_ff != 8'h00;

   // R6 interval interrupt
   assign evSet[WDT_IRQ_TIMEOUT_BIT] = underflow && !wdMode;
   assign evSet[WDT_IRQ_BADFEED_BIT] = wrEn && byte0 && !hiBank
      && ofs == WDT_FEED_OFS && !feedOk
      && wb_dat_i[7:0] != WDT_FEED_FIRST;

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqStat_ff <= 2'h0;
      end else if (wrEn && byte0 && hiBank && ofs == WDT_IRQST_OFS) begin
         irqStat_ff <= (irqStat_ff & ~wb_dat_i[1:0]) | evSet;
      end else begin
         irqStat_ff <= irqStat_ff | evSet;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqMask_ff <= WDT_IRQMSK_RST;
      end else if (wrEn && byte0 && hiBank && ofs == WDT_IRQMSK_OFS) begin
         irqMask_ff <= wb_dat_i[1:0];
      end
   end
   assign irq = |(irqStat_ff & irqMask_ff);

   always_comb begin
      nxt_rdData = 32'h0;
      if (!hiBank) begin
         unique case (ofs)
            WDT_CTRL_OFS:   nxt_rdData = {24'h0, ctrl_ff};
            WDT_RELOAD_OFS: nxt_rdData = {24'h0, reload_ff};
            WDT_STATUS_OFS: nxt_rdData = {24'h0, count_ff};
            default:        nxt_rdData = 32'h0;
         endcase
      end else begin
         unique case (ofs)
            WDT_IRQST_OFS:  nxt_rdData = {30'h0, irqStat_ff};
            WDT_IRQMSK_OFS: nxt_rdData = {30'h0, irqMask_ff};
            default:        nxt_rdData = 32'h0;
         endcase
      end
   end

   // Unmapped addresses still ack, reading zero.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? nxt_rdData : 32'h0;
      end
   end
endmodule : wdt_interval_timer
`default_nettype wire

/* testbench/wdt_interval_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_interval_timer_sva #(
   parameter int RESET_CYCLES = 10
) (
   // Clock and reset.
   input wire logic        clock,
   input wire logic        rst,
   // Bus.
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Outputs.
   input wire logic        systemResetReq,
   input wire logic        irq
);
   // Cycles the reset request has stood so far.
   logic [7:0] srrLen_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         srrLen_ff <= 8'h00;
      end else if (systemResetReq) begin
         srrLen_ff <= srrLen_ff + 8'h01;
      end else begin
         srrLen_ff <= 8'h00;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("data outside ack");
   AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper data set");
   AST_SRR_HOLD: assert property (
      $rose(systemResetReq) |-> systemResetReq [*2])
      else $error("reset pulse short");
   AST_SRR_END: assert property (
      $rose(systemResetReq) |=> ##[1:11] !systemResetReq)
      else $error("reset pulse stuck");
   AST_SRR_LEN: assert property (
      $fell(systemResetReq) |-> srrLen_ff == 8'(RESET_CYCLES))
      else $error("reset pulse length wrong");
   AST_QUIET: assert property ($fell(rst) |-> !systemResetReq && !irq)
      else $error("outputs active after reset");
endmodule : wdt_interval_timer_sva
bind wdt_interval_timer wdt_interval_timer_sva #(
   .RESET_CYCLES (RESET_CYCLES)
) u_sva (
   .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .systemResetReq(systemResetReq), .irq(irq));
`default_nettype wire

/* testbench/wdt_interval_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_interval_timer_tb
   import wdt_pkg::*;
;
   localparam logic [4:0] CT = {1'b0, WDT_CTRL_OFS};
   localparam logic [4:0] RL = {1'b0, WDT_RELOAD_OFS};
   localparam logic [4:0] FD = {1'b0, WDT_FEED_OFS};
   localparam logic [4:0] CN = {1'b0, WDT_STATUS_OFS};
   localparam logic [4:0] ST = {1'b1, WDT_IRQST_OFS};
   localparam logic [4:0] MK = {1'b1, WDT_IRQMSK_OFS};
   logic        clock = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic        osc = 0, pd = 0, ack, srr, irq;
   logic [4:0]  adr = 0;
   logic [3:0]  sel = 4'hF;
   logic [31:0] dat = 0, rd, dout;
   int          badCount = 0, testsRun = 0, cycleCount = 0, hits = 0;
   wdt_interval_timer #(.RESET_CYCLES(2)) u_wdt_interval_timer (
      .clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
      .wb_ack_o(ack), .peripheralClkTick(1'b1), .watchdogOsc(osc),
      .powerDown(pd), .systemResetReq(srr), .irq(irq));
   always #2 clock = ~clock;
   // The oscillator is slow, one period per eight clocks, as the synchroniser expects.
   always #16 osc = ~osc;
   always @(posedge clock) begin
      cycleCount++;
      if (srr === 1'b1) hits++;
      if (cycleCount == 5000) begin
         badCount++;
         finalReport();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      testsRun++;
      if (s !== e) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do @(posedge clock); while (ack !== 1'b1);
      rd = dout;
      cyc <= 0;
      stb <= 0;
   endtask : wb
   task automatic rdc(input string n, input logic [4:0] a, logic [31:0] e);
      wb(0, a, 8'h00);
      chk(n, rd, e);
   endtask : rdc
   task automatic feed();
      wb(1, FD, WDT_FEED_FIRST);
      wb(1, FD, WDT_FEED_SECOND);
   endtask : feed
   task automatic tReset();
      rdc("ctrl", CT, {24'h0, WDT_CTRL_RST});
      rdc("reload", RL, {24'h0, WDT_RELOAD_RST});
      rdc("count", CN, 32'hFF);
      rdc("mask", MK, 32'h0);
      rdc("status", ST, 32'h0);
      rdc("unmapped", 5'h18, 32'h0);
      // A write with byte lane 0 off must leave the register alone.
      sel <= 4'h0;
      wb(1, RL, 8'h12);
      sel <= 4'hF;
      rdc("selIgnored", RL, {24'h0, WDT_RELOAD_RST});
   endtask : tReset
   task automatic tInterval();
      wb(1, RL, 8'h02);
      wb(1, MK, 8'h01);
      // Stopping first reloads the counter and clears the prescaler.
      wb(1, CT, 8'h00);
      wb(1, CT, 8'h01);
      repeat (70) @(posedge clock);
      chk("irqEarly", {31'h0, irq}, 32'h0);
      repeat (20) @(posedge clock);
      chk("irqTimeout", {31'h0, irq}, 32'h1);
      chk("noResetInterval", hits, 0);
      wb(1, MK, 8'h00);
      chk("irqMasked", {31'h0, irq}, 32'h0);
      wb(1, MK, 8'h01);
      rdc("statusSet", ST, 32'h1);
      wb(1, ST, 8'h01);
      chk("irqCleared", {31'h0, irq}, 32'h0);
   endtask : tInterval
   task automatic tWatchdog();
      wb(1, CT, 8'h02);
      wb(1, CT, 8'h03);
      feed();
      wb(1, ST, 8'h03);
      repeat (4) begin
         repeat (60) @(posedge clock);
         feed();
      end
      chk("fedNoReset", hits, 0);
      repeat (20) @(posedge clock);
      wb(1, FD, WDT_FEED_FIRST);
      wb(1, RL, 8'h02);
      wb(1, FD, WDT_FEED_SECOND);
      repeat (30) @(posedge clock);
      chk("brokenEarly", hits, 0);
      repeat (40) @(posedge clock);
      chk("underflowReset", {31'h0, hits != 0}, 32'h1);
      rdc("ctrlKept", CT, 32'h3);
      wb(1, ST, 8'h03);
      rdc("badFeedClr", ST, 32'h0);
      wb(1, FD, 8'h33);
      wb(0, ST, 8'h00);
      chk("badFeed", rd, 32'h2);
   endtask : tWatchdog
   task automatic tPower();
      wb(1, CT, 8'h00);
      pd <= 1;
      wb(1, CT, 8'h01);
      repeat (400) @(posedge clock);
      rdc("countPowerDown", CN, 32'h2);
      chk("irqPowerDown", {31'h0, irq}, 32'h0);
      wb(1, CT, 8'h05);
      repeat (250) @(posedge clock);
      rdc("countOsc", CN, 32'h1);
   endtask : tPower
   task automatic tRestart();
      rst <= 1;
      repeat (5) @(posedge clock);
      rst <= 0;
      rdc("ctrlPor", CT, {24'h0, WDT_CTRL_RST});
      rdc("countPor", CN, {24'h0, WDT_RELOAD_RST});
      rdc("statusPor", ST, 32'h0);
   endtask : tRestart
   task automatic finalReport();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finalReport
   initial begin
      repeat (5) @(posedge clock);
      rst <= 0;
      tReset();
      tInterval();
      tWatchdog();
      tPower();
      tRestart();
      finalReport();
   end
endmodule : wdt_interval_timer_tb
`default_nettype wire
